// ### rtl/psd_pin_share.sv
// shared-pin owner selection with gpio registers and strap latch
// Summary of operation
// - clock-shared pins default to clock function
// - gpio four to seven feed external interrupts
// - pci-shared gpio pins default to nothing
// - host port owns pins unless pci selected
// - pci pins default to partner functions
// - serial port pins default to serial functions
// - pin eight defaults to serial clock source
// - utopia pins default to serial port one
// - selection straps latched while reset asserted
//
// Decided for this implementation: strobed register access and the register offsets.
module psd_pin_share
	import psd_pkg::*;
#(
	parameter int GW = PSD_GPIO_W
) (
	input  wire logic          clk_sys,
	input  wire logic          sys_rst,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [31:0]   reg_rdata,
	input  wire logic          strap_pci_en,
	input  wire logic          strap_utopia_en,
	input  wire logic [GW-1:0] gpio_pin_in,
	output logic      [GW-1:0] gpio_pin_out,
	output logic      [GW-1:0] gpio_pin_oe,
	input  wire logic          clock_output_div_four,
	input  wire logic          clock_output_div_six,
	input  wire logic          serial_port2_clock_source_out,
	input  wire logic          serial_port2_clock_source_oe,
	output logic      [3:0]    external_interrupt_inputs,
	output logic               serial_port2_clock_source_in,
	output logic               host_port_owns,
	output logic               pci_owns,
	output logic               serial_port_two_owns,
	output logic               serial_port_one_owns,
	output logic               utopia_owns,
	output logic               pci_gpio_owns
);
	////////////////////////////////////////////////////////////////////////
	// strap capture
	logic [1:0] strap_sync;
	// straps must stay live in reset, so this synchroniser never resets
	psd_sync #(.W(2)) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (1'b0),
		.d       ({strap_utopia_en, strap_pci_en}),
		.q       (strap_sync)
	);

	psd_state_t state_ff, nxt_state;
	psd_sel_t   sel_ff, nxt_sel;

	// state and selection move only here; the flops just register
	always_comb begin
		nxt_state = state_ff;
		nxt_sel   = sel_ff;
		case (state_ff)
			PSD_ST_RESET: begin
				nxt_state = PSD_ST_LATCH;
			end
			PSD_ST_LATCH: begin
				// reset gone: last latched straps kept
				nxt_state = PSD_ST_RUN;
			end
			PSD_ST_RUN: begin
				nxt_state = PSD_ST_RUN;
			end
			default: begin
				nxt_state = PSD_ST_RESET;
			end
		endcase
		if (sys_rst) begin
			// sample straps while reset held
			nxt_state         = PSD_ST_LATCH;
			nxt_sel.pci_en    = strap_sync[PSD_SEL_PCI];
			nxt_sel.utopia_en = strap_sync[PSD_SEL_UTOPIA];
		end
	end

	always_ff @(posedge clk_sys) begin
		state_ff <= nxt_state;
		sel_ff   <= nxt_sel;
	end

	////////////////////////////////////////////////////////////////////////
	// gpio registers
	logic [GW-1:0] en_ff, dir_ff, out_ff;
	logic [GW-1:0] nxt_en, nxt_dir, nxt_out;
	logic [31:0]   rdata_ff, nxt_rdata;
	logic [GW-1:0] pin_in_sync;

	// pin levels, three flops with agreement
	psd_sync #(.W(GW)) u_gsync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.d       (gpio_pin_in),
		.q       (pin_in_sync)
	);

	always_comb begin
		nxt_en    = en_ff;
		nxt_dir   = dir_ff;
		nxt_out   = out_ff;
		nxt_rdata = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				PSD_REG_EN:  nxt_en  = reg_wdata[GW-1:0];
				PSD_REG_DIR: nxt_dir = reg_wdata[GW-1:0];
				PSD_REG_OUT: nxt_out = reg_wdata[GW-1:0];
				default:     nxt_out = out_ff;
			endcase
		end
		// reads answer one cycle later, else zero
		if (reg_rd) begin
			case (reg_addr)
				PSD_REG_EN:  nxt_rdata[GW-1:0] = en_ff;
				PSD_REG_DIR: nxt_rdata[GW-1:0] = dir_ff;
				PSD_REG_OUT: nxt_rdata[GW-1:0] = pin_in_sync;
				PSD_REG_SEL: nxt_rdata[1:0]    = {sel_ff.utopia_en, sel_ff.pci_en};
				default:     nxt_rdata         = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_ff    <= PSD_EN_RST;
			dir_ff   <= PSD_DIR_RST;
			out_ff   <= '0;
			rdata_ff <= 32'h0;
		end else begin
			en_ff    <= nxt_en;
			dir_ff   <= nxt_dir;
			out_ff   <= nxt_out;
			rdata_ff <= nxt_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin ownership
	logic [GW-1:0] nxt_pout, nxt_poe, pout_ff, poe_ff;
	logic [3:0]    nxt_xint, xint_ff;
	logic          nxt_ck2, ck2_ff;
	logic [5:0]    nxt_own, own_ff;

	always_comb begin
		nxt_pout = '0;
		nxt_poe  = '0;
		nxt_ck2  = 1'b0;
		for (int i = 0; i < GW; i++) begin
			if (PSD_PCI_GPIO[i] && sel_ff.pci_en) begin
				// pci owns pin; gpio side off
				nxt_poe[i] = 1'b0;
			end else if (PSD_PCI_GPIO[i] && !en_ff[i]) begin
				nxt_poe[i] = 1'b0;
			end else if (psd_is_clk_pin(i) && !en_ff[i]) begin
				// clock function until gpio enabled
				if (i == PSD_CLK4_PIN) begin
					nxt_pout[i] = clock_output_div_four;
					nxt_poe[i]  = 1'b1;
				end else if (i == PSD_CLK6_PIN) begin
					nxt_pout[i] = clock_output_div_six;
					nxt_poe[i]  = 1'b1;
				end else begin
					nxt_pout[i] = serial_port2_clock_source_out;
					nxt_poe[i]  = serial_port2_clock_source_oe;
					nxt_ck2     = pin_in_sync[i];
				end
			end else if (i >= PSD_INT_LO && i <= PSD_INT_HI && !en_ff[i]) begin
				nxt_poe[i] = 1'b0;
			end else begin
				nxt_pout[i] = out_ff[i];
				nxt_poe[i]  = en_ff[i] & dir_ff[i];
			end
		end
		nxt_xint = pin_in_sync[PSD_INT_HI:PSD_INT_LO];
		// gpio holds a pci-shared pin only while pci is off
		nxt_own  = {
			!sel_ff.pci_en,
			sel_ff.pci_en,
			!sel_ff.pci_en,
			!sel_ff.utopia_en,
			sel_ff.utopia_en,
			!sel_ff.pci_en && (|(en_ff & PSD_PCI_GPIO[GW-1:0]))
		};
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pout_ff <= '0;
			poe_ff  <= '0;
			xint_ff <= 4'h0;
			ck2_ff  <= 1'b0;
			// host and both serial ports own at reset
			own_ff  <= PSD_OWN_RST;
		end else begin
			pout_ff <= nxt_pout;
			poe_ff  <= nxt_poe;
			xint_ff <= nxt_xint;
			ck2_ff  <= nxt_ck2;
			own_ff  <= nxt_own;
		end
	end

	assign reg_rdata                    = rdata_ff;
	assign gpio_pin_out                 = pout_ff;
	assign gpio_pin_oe                  = poe_ff;
	assign external_interrupt_inputs    = xint_ff;
	assign serial_port2_clock_source_in = ck2_ff;
	assign host_port_owns               = own_ff[5];
	assign pci_owns                     = own_ff[4];
	assign serial_port_two_owns         = own_ff[3];
	assign serial_port_one_owns         = own_ff[2];
	assign utopia_owns                  = own_ff[1];
	assign pci_gpio_owns                = own_ff[0];
endmodule : psd_pin_share

// ### rtl/psd_pkg.sv
// package: pin-sharing constants and carrier types
package psd_pkg;

	localparam int          PSD_GPIO_W      = 16;
	localparam int          PSD_INT_LO      = 4;
	localparam int          PSD_INT_HI      = 7;
	localparam int          PSD_PIN8        = 8;
	localparam int          PSD_SYNC_STAGES = 3;
	localparam logic [15:0] PSD_EN_RST      = 16'h0000;
	localparam logic [15:0] PSD_DIR_RST     = 16'h0000;
	localparam logic [1:0]  PSD_STRAP_RST   = 2'h0;
	// owners at reset: host port and both serial ports
	localparam logic [5:0]  PSD_OWN_RST     = 6'h2c;
	// clock-shared gpio pins (div-four and div-six outputs)
	localparam int          PSD_CLK4_PIN    = 1;
	localparam int          PSD_CLK6_PIN    = 2;
	// gpio pins shared with pci
	localparam logic [15:0] PSD_PCI_GPIO    = 16'hfe00;
	// register offsets and fields
	localparam logic [3:0]  PSD_REG_EN      = 4'h0;
	localparam logic [3:0]  PSD_REG_DIR     = 4'h4;
	localparam logic [3:0]  PSD_REG_OUT     = 4'h8;
	localparam logic [3:0]  PSD_REG_SEL     = 4'hc;
	localparam int          PSD_SEL_PCI     = 0;
	localparam int          PSD_SEL_UTOPIA  = 1;

	typedef struct packed {
		logic pci_en;
		logic utopia_en;
	} psd_sel_t;

	typedef enum logic [2:0] {
		PSD_ST_RESET = 3'b001,
		PSD_ST_LATCH = 3'b010,
		PSD_ST_RUN   = 3'b100
	} psd_state_t;

	function automatic logic psd_is_clk_pin(input int idx);
		return (idx == PSD_CLK4_PIN) || (idx == PSD_CLK6_PIN) || (idx == PSD_PIN8);
	endfunction : psd_is_clk_pin

endpackage : psd_pkg

// ### rtl/psd_sync.sv
// three-stage input synchroniser with agreement filter
module psd_sync
	import psd_pkg::*;
#(
	parameter int W = 2
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
	logic [W-1:0] nxt_q;

	always_comb begin
		nxt_q = q_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_q[i] = s2_ff[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff  <= '0;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff  <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule : psd_sync

// ### testbench/psd_board.sv
// board model: pulled pin levels where the device does not drive
module psd_board (
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] ext_lvl,
	output logic      [15:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ns;
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : psd_board

// ### testbench/psd_monitor.sv
// checker: pin ownership and read port properties
module psd_monitor
	import psd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] gpio_pin_oe,
	input wire logic        host_port_owns,
	input wire logic        pci_owns,
	input wire logic        serial_port_two_owns,
	input wire logic        serial_port_one_owns,
	input wire logic        utopia_owns,
	input wire logic        pci_gpio_owns
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_hp; host_port_owns != pci_owns; endproperty
	a_hp: assert property (p_hp) else $error("host owner clash");
	property p_s2; serial_port_two_owns != pci_owns; endproperty
	a_s2: assert property (p_s2) else $error("port two owner clash");
	property p_s1; serial_port_one_owns != utopia_owns; endproperty
	a_s1: assert property (p_s1) else $error("port one owner clash");
	property p_pg; pci_owns |-> (gpio_pin_oe & PSD_PCI_GPIO) == 16'h0000; endproperty
	a_pg: assert property (p_pg) else $error("gpio drives pci pin");
	property p_px; pci_gpio_owns |-> !pci_owns; endproperty
	a_px: assert property (p_px) else $error("double pin owner");
	property p_rd; !$past(reg_rd) |-> reg_rdata == 32'h00000000; endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
	property p_ps; !$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(pci_owns); endproperty
	a_ps: assert property (p_ps) else $error("pci select moved");
	property p_us; !$past(sys_rst) ##1 !$past(sys_rst) |-> $stable(utopia_owns); endproperty
	a_us: assert property (p_us) else $error("utopia select moved");
	c_pci: cover property (pci_owns);
	c_ut: cover property (utopia_owns);
	c_rd: cover property (reg_rd ##1 reg_rdata != 32'h00000000);
	c_gp: cover property (pci_gpio_owns);
endmodule : psd_monitor
bind psd_pin_share psd_monitor psd_monitor_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_pin_oe(gpio_pin_oe),
	.host_port_owns(host_port_owns), .pci_owns(pci_owns), .utopia_owns(utopia_owns),
	.serial_port_two_owns(serial_port_two_owns), .pci_gpio_owns(pci_gpio_owns),
	.serial_port_one_owns(serial_port_one_owns));

// ### testbench/testbench.sv
// testbench: random pin-sharing stimulus with self checks
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import psd_pkg::*;
	logic        clk_sys, sys_rst, reg_wr, reg_rd, sp, su, c4, c6, s2o, s2e, s2i;
	logic [3:0]  reg_addr, eii;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] lvl, po, poe, ext, en, dir, ov, eo, el;
	wire  [5:0]  own;
	int          seed, n_errors, checks_done, cyc;
	psd_pin_share psd_pin_share_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .strap_pci_en(sp), .strap_utopia_en(su), .gpio_pin_in(lvl),
		.gpio_pin_out(po), .gpio_pin_oe(poe), .clock_output_div_four(c4),
		.clock_output_div_six(c6), .serial_port2_clock_source_out(s2o),
		.serial_port2_clock_source_oe(s2e), .external_interrupt_inputs(eii),
		.serial_port2_clock_source_in(s2i), .host_port_owns(own[5]), .pci_owns(own[4]),
		.serial_port_two_owns(own[3]), .serial_port_one_owns(own[2]),
		.utopia_owns(own[1]), .pci_gpio_owns(own[0]));
	psd_board psd_board_inst (.pin_out(po), .pin_oe(poe), .ext_lvl(ext), .pin_lvl(lvl));
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one register cycle, read data sampled after the answer edge
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= {16'h0000, d};
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask : acc
	function automatic logic [15:0] f_oe(input logic pci);
		logic [15:0] m;
		m = en & dir;
		if (pci) m &= ~PSD_PCI_GPIO;
		if (!en[PSD_CLK4_PIN]) m[PSD_CLK4_PIN] = 1'b1;
		if (!en[PSD_CLK6_PIN]) m[PSD_CLK6_PIN] = 1'b1;
		if (!en[PSD_PIN8]) m[PSD_PIN8] = s2e;
		return m;
	endfunction : f_oe
	function automatic logic [15:0] f_out();
		logic [15:0] m;
		m = ov;
		if (!en[PSD_CLK4_PIN]) m[PSD_CLK4_PIN] = c4;
		if (!en[PSD_CLK6_PIN]) m[PSD_CLK6_PIN] = c6;
		if (!en[PSD_PIN8]) m[PSD_PIN8] = s2o;
		return m;
	endfunction : f_out
	function automatic logic [5:0] f_own(input logic pci, input logic ut);
		return {!pci, pci, !pci, !ut, ut, !pci && ((en & PSD_PCI_GPIO) != 16'h0000)};
	endfunction : f_own
	task automatic pins(input logic pci);
		repeat (8) @(posedge clk_sys);
		#1;
		eo = f_oe(pci);
		el = (eo & f_out()) | (~eo & ext);
		chk("pin_oe", poe, eo);
		chk("pin_out", po & eo, f_out() & eo);
		chk("ext_int", eii, el[7:4]);
		if (!en[PSD_PIN8]) chk("clk_src_in", s2i, el[PSD_PIN8]);
		acc(1'b0, PSD_REG_OUT, 16'h0000);
		chk("rd_pins", reg_rdata, el);
	endtask : pins
	initial begin
		{clk_sys, sys_rst, reg_wr, reg_rd, sp, su, c4, c6, s2o, s2e} = 10'h100;
		{reg_addr, reg_wdata, ext, en, dir, ov} = '0;
		{seed, n_errors, checks_done, cyc} = {32'd78, 96'd0};
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			sys_rst <= 1'b1;
			sp <= k[0];
			su <= k[1];
			{en, dir, ov} = '0;
			repeat (12) @(posedge clk_sys);
			#1;
			chk("oe_in_reset", poe, 0);
			chk("own_in_reset", own, PSD_OWN_RST);
			@(posedge clk_sys);
			sys_rst <= 1'b0;
			sp <= ~k[0];
			su <= ~k[1];
			for (int j = 0; j < 4; j++) begin
				@(posedge clk_sys);
				{c4, c6, s2o, s2e} <= 4'($random(seed));
				ext <= 16'($random(seed));
				if (j > 0) begin
					en = (j == 3) ? 16'hffff : 16'($random(seed));
					dir = 16'($random(seed));
					ov = 16'($random(seed));
					acc(1'b1, PSD_REG_EN, en);
					acc(1'b1, PSD_REG_DIR, dir);
					acc(1'b1, PSD_REG_OUT, ov);
					acc(1'b1, PSD_REG_SEL, 16'hffff);
				end
				pins(k[0]);
				chk("owners", own, f_own(k[0], k[1]));
				acc(1'b0, PSD_REG_EN, 16'h0000);
				chk("rd_enable", reg_rdata, en);
				acc(1'b0, 4'h2, 16'h0000);
				chk("rd_unmapped", reg_rdata, 0);
				acc(1'b0, PSD_REG_SEL, 16'h0000);
				chk("rd_sel", reg_rdata, {k[1], k[0]});
			end
			$display("test %0d done", k);
		end
		complete_run();
	end
endmodule : testbench
